// ==== design/irq_pkg.sv ====
// package: register map, field layout and timing for the irq/wake block
package irq_pkg;
   localparam int unsigned CLK_HZ    = 10_000_000;
   localparam int unsigned POWERUP_DELAY_TIMER_MS   = 72;
   localparam int unsigned POWERUP_DELAY_TIMER_CYC  = POWERUP_DELAY_TIMER_MS * (CLK_HZ / 1000);
   localparam int unsigned OST_CYC   = 1024;
   localparam int unsigned IRQ_DELAY = 2;

   localparam logic [2:0] ADDR_CTRL   = 3'h0;
   localparam logic [2:0] ADDR_OPTION = 3'h1;
   localparam logic [2:0] ADDR_EECTRL = 3'h2;
   localparam logic [2:0] ADDR_STATUS = 3'h3;

   localparam int B_GLOBAL_EN = 7;
   localparam int B_EDGE_SEL  = 6;
   localparam int B_EE_FLAG   = 4;

   localparam int SRC_PC  = 0;
   localparam int SRC_EXT = 1;
   localparam int SRC_OVF = 2;
   localparam int SRC_EE  = 3;
   localparam int NUM_SRC = 4;

   localparam logic [7:0]  OPTION_RST   = 8'hff;
   localparam logic [3:0]  FLAG_RST_CLR = 4'h6;
   localparam logic [12:0] VECTOR_ADDR  = 13'h0004;

   typedef struct packed {
      logic ee;
      logic ovf;
      logic ext;
      logic pc;
   } src_vec_s;

   typedef struct packed {
      logic wdt_expiry;
      logic sleep_entered;
   } reset_cause_s;

   function automatic logic any_src(input logic [3:0] f,
                                    input logic [3:0] e);
      return |(f & e);
   endfunction
endpackage

// ==== design/irq_event_detect.sv ====
// source event detection: pin edge, port change, timer rollover
module irq_event_detect
   import irq_pkg::*;
#(
   parameter int unsigned NIB_W = 4
)(
   // clock and reset
   input  wire logic             core_clk_i,
   input  wire logic             resetn_i,
   // sources
   input  wire logic             edge_sel_i,
   input  wire logic             ext_irq_pin_i,
   input  wire logic [NIB_W-1:0] upper_nibble_port_i,
   input  wire logic [7:0]       timer_zero_count_i,
   input  wire logic             ee_write_done_i,
   // one-cycle events
   output src_vec_s              events_o
);
   logic             primed;
   logic             pin_q;
   logic [NIB_W-1:0] port_q;
   logic [7:0]       cnt_q;
   wire              rise = ext_irq_pin_i & ~pin_q;
   wire              fall = ~ext_irq_pin_i & pin_q;

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         primed <= 1'b0;
         pin_q  <= 1'b0;
         port_q <= '0;
         cnt_q  <= 8'h00;
      end else begin
         primed <= 1'b1;
         pin_q  <= ext_irq_pin_i;
         port_q <= upper_nibble_port_i;
         cnt_q  <= timer_zero_count_i;
      end
   end

   assign events_o.ext = primed & (edge_sel_i ? rise : fall);
   assign events_o.pc  = primed & (upper_nibble_port_i != port_q);
   assign events_o.ovf = primed & (cnt_q == 8'hff)
                         & (timer_zero_count_i == 8'h00);
   assign events_o.ee  = ee_write_done_i;
endmodule

// ==== design/startup_timer.sv ====
// start-up delay sequencer: power-up delay, then oscillator start-up (skipped in rc mode)
module startup_timer
   import irq_pkg::*;
#(
   parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = POWERUP_DELAY_TIMER_CYC,
   parameter int unsigned OST_CYCLES  = OST_CYC,
   parameter int unsigned CNT_W       = 20
)(
   // clock and reset
   input  wire logic core_clk_i,
   input  wire logic resetn_i,
   // triggers and straps
   input  wire logic por_start_i,
   input  wire logic wake_i,
   input  wire logic powerup_delay_timer_en_i,
   input  wire logic rc_mode_i,
   // status
   output logic      busy_o
);
   typedef enum logic [1:0] {ST_IDLE, ST_POWERUP_DELAY_TIMER, ST_OST} state_e;

   localparam logic [CNT_W-1:0] POWERUP_DELAY_TIMER_LAST = CNT_W'(POWERUP_DELAY_TIMER_CYCLES - 1);
   localparam logic [CNT_W-1:0] OST_LAST  = CNT_W'(OST_CYCLES - 1);

   state_e           state;
   state_e           next_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic             rc_mode;

   always_comb begin
      next_state = state;
      next_cnt   = cnt + 1'b1;
      unique case (state)
         ST_IDLE: begin
            next_cnt = '0;
            if (por_start_i && powerup_delay_timer_en_i) begin
               next_state = ST_POWERUP_DELAY_TIMER;
            end else if (por_start_i && !rc_mode_i) begin
               next_state = ST_OST;
            end else if (wake_i && !rc_mode) begin
               next_state = ST_OST;
            end
         end
         ST_POWERUP_DELAY_TIMER: begin
            if (cnt == POWERUP_DELAY_TIMER_LAST) begin
               next_cnt   = '0;
               next_state = rc_mode ? ST_IDLE : ST_OST;
            end
         end
         ST_OST: begin
            if (cnt == OST_LAST) begin
               next_state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state   <= ST_IDLE;
         cnt     <= '0;
         rc_mode <= 1'b0;
      end else begin
         state   <= next_state;
         cnt     <= next_cnt;
         rc_mode <= por_start_i ? rc_mode_i : rc_mode;
      end
   end

   assign busy_o = (state != ST_IDLE);
endmodule

// ==== design/irq_wake_reset_status.sv ====
// interrupt controller with reset cause, sleep and wake control
//
// Our own choices: the address-and-strobe port and the register offsets.
module irq_wake_reset_status
   import irq_pkg::*;
#(
   parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = POWERUP_DELAY_TIMER_CYC,
   parameter int unsigned OST_CYCLES  = OST_CYC
)(
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        resetn_i,
   // register port
   input  wire logic [2:0]  addr_i,
   input  wire logic [7:0]  wr_data_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [7:0]  rd_data_o,
   // configuration straps
   input  wire logic        cfg_powerup_delay_timer_en_i,
   input  wire logic        cfg_rc_mode_i,
   // reset pin and watchdog
   input  wire logic        ext_reset_n_i,
   input  wire logic        watchdog_timeout_i,
   // interrupt sources
   input  wire logic        ext_irq_pin_i,
   input  wire logic [3:0]  upper_nibble_port_i,
   input  wire logic [7:0]  timer_zero_count_i,
   input  wire logic        ee_write_done_i,
   // core operations
   input  wire logic        return_from_irq_op_i,
   input  wire logic        sleep_op_i,
   input  wire logic        watchdog_clear_op_i,
   // core control
   output logic             core_hold_o,
   output logic             core_run_o,
   output logic             asleep_o,
   output logic             vector_take_o,
   output logic      [12:0] vector_addr_o,
   output logic             watchdog_clear_o,
   output reset_cause_s     cause_o
);
   src_vec_s     events;
   logic [3:0]   flags;
   logic [3:0]   next_flag;
   logic [3:0]   en;
   logic         global_irq_enable;
   logic         next_gie;
   logic [7:0]   option;
   reset_cause_s cause;
   reset_cause_s next_cause;
   logic         asleep;
   logic         next_asleep;
   logic         core_hold;
   logic         por_start;
   logic         por_phase;
   logic         tmr_busy;
   logic [1:0]   lat_cnt;
   logic         vector_take;
   logic [12:0]  vector_addr;
   logic         wdt_clear;
   logic         core_run;
   logic [7:0]   rd_data;
   logic         wake_now;
   logic [10:0]  wake_wait;

   irq_event_detect #(
      .NIB_W (4)
   ) u_events (
      .core_clk_i          (core_clk_i),
      .resetn_i            (resetn_i),
      .edge_sel_i          (option[B_EDGE_SEL]),
      .ext_irq_pin_i       (ext_irq_pin_i),
      .upper_nibble_port_i (upper_nibble_port_i),
      .timer_zero_count_i  (timer_zero_count_i),
      .ee_write_done_i     (ee_write_done_i),
      .events_o            (events)
   );

   startup_timer #(
      .POWERUP_DELAY_TIMER_CYCLES (POWERUP_DELAY_TIMER_CYCLES),
      .OST_CYCLES  (OST_CYCLES),
      .CNT_W       (20)
   ) u_startup (
      .core_clk_i  (core_clk_i),
      .resetn_i    (resetn_i),
      .por_start_i (por_start),
      .wake_i      (wake_now),
      .powerup_delay_timer_en_i   (cfg_powerup_delay_timer_en_i),
      .rc_mode_i   (cfg_rc_mode_i),
      .busy_o      (tmr_busy)
   );

   // decode
   wire wr_ctrl  = wr_i & (addr_i == ADDR_CTRL);
   wire wr_opt   = wr_i & (addr_i == ADDR_OPTION);
   wire wr_ee    = wr_i & (addr_i == ADDR_EECTRL);
   wire running  = ~core_hold & ~asleep & ~tmr_busy;
   wire wdt_rst  = watchdog_timeout_i & running;
   wire other_rst = ~ext_reset_n_i | wdt_rst;
   wire pending  = any_src(flags, en);
   wire req      = global_irq_enable & pending & running;
   wire take_now = req & (lat_cnt == 2'(IRQ_DELAY - 1));
   // no-op when global off and pending
   wire sleep_do = sleep_op_i & running & ~(~global_irq_enable & pending);
   wire wake_cond = asleep & (pending | watchdog_timeout_i);
   assign wake_now = wake_cond & ext_reset_n_i & ~core_hold;
   wire [3:0] flag_we = {wr_ee, wr_ctrl, wr_ctrl, wr_ctrl};
   wire [3:0] flag_wd = {wr_data_i[B_EE_FLAG], wr_data_i[2:0]};

   genvar g;
   generate
      for (g = 0; g < NUM_SRC; g++) begin : g_flag
         assign next_flag[g] = (other_rst & FLAG_RST_CLR[g]) ? 1'b0 :
                               events[g] |
                               (flag_we[g] ? flag_wd[g] : flags[g]);
         always_ff @(posedge core_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               flags[g] <= 1'b0;
            end else begin
               flags[g] <= next_flag[g];
            end
         end
      end
   endgenerate

   assign next_gie = other_rst ? 1'b0 :
                     take_now ? 1'b0 :
                     wr_ctrl ? wr_data_i[B_GLOBAL_EN] :
                     (return_from_irq_op_i & running) ? 1'b1 : global_irq_enable;

   assign next_asleep = ~ext_reset_n_i ? asleep :
                        core_hold ? 1'b0 :
                        sleep_do ? 1'b1 :
                        wake_cond ? 1'b0 : asleep;

   always_comb begin
      next_cause = cause;
      if (!ext_reset_n_i) begin
         next_cause = '{wdt_expiry: 1'b1, sleep_entered: ~asleep};
      end else if (watchdog_timeout_i && asleep) begin
         next_cause = '{wdt_expiry: 1'b0, sleep_entered: 1'b0};
      end else if (wdt_rst) begin
         next_cause = '{wdt_expiry: 1'b0, sleep_entered: 1'b1};
      end else if (sleep_do) begin
         next_cause = '{wdt_expiry: 1'b1, sleep_entered: 1'b0};
      end else if (watchdog_clear_op_i && running) begin
         next_cause = '{wdt_expiry: 1'b1, sleep_entered: 1'b1};
      end
   end

   wire [7:0] rd_mux =
      (addr_i == ADDR_CTRL)   ? {global_irq_enable, en, flags[2:0]} :
      (addr_i == ADDR_OPTION) ? option :
      (addr_i == ADDR_EECTRL) ? {3'h0, flags[SRC_EE], 4'h0} :
      (addr_i == ADDR_STATUS) ? {6'h00, cause} : 8'h00;

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         en    <= 4'h0;
         global_irq_enable   <= 1'b0;
         option <= OPTION_RST;
         cause <= '{wdt_expiry: 1'b1, sleep_entered: 1'b1};
         asleep <= 1'b0;
      end else begin
         en    <= other_rst ? 4'h0 : (wr_ctrl ? wr_data_i[6:3] : en);
         global_irq_enable   <= next_gie;
         option <= other_rst ? OPTION_RST :
                   (wr_opt ? wr_data_i : option);
         cause <= next_cause;
         asleep <= next_asleep;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         por_start <= 1'b1;
         por_phase <= 1'b1;
         core_hold <= 1'b1;
      end else begin
         por_start <= 1'b0;
         por_phase <= por_phase & (por_start | tmr_busy);
         core_hold <= (por_phase & (por_start | tmr_busy)) |
                      other_rst;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lat_cnt     <= 2'h0;
         vector_take <= 1'b0;
         vector_addr <= 13'h0000;
      end else begin
         lat_cnt     <= (req & ~take_now) ? lat_cnt + 2'h1 : 2'h0;
         vector_take <= take_now;
         vector_addr <= take_now ? VECTOR_ADDR : vector_addr;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wdt_clear <= 1'b0;
         core_run  <= 1'b0;
         rd_data   <= 8'h00;
      end else begin
         wdt_clear <= sleep_do | (watchdog_clear_op_i & running);
         core_run  <= running;
         rd_data   <= rd_i ? rd_mux : 8'h00;
      end
   end

   assign rd_data_o        = rd_data;
   assign core_hold_o      = core_hold;
   assign core_run_o       = core_run;
   assign asleep_o         = asleep;
   assign vector_take_o    = vector_take;
   assign vector_addr_o    = vector_addr;
   assign watchdog_clear_o = wdt_clear;
   assign cause_o          = cause;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);

   gie_reset_clr_a: assert property (
      !ext_reset_n_i |=> !global_irq_enable)
      else $error("global enable not cleared by reset");
   rfi_sets_gie_a: assert property (
      return_from_irq_op_i && running && !other_rst && !take_now
      && !wr_ctrl |=> global_irq_enable)
      else $error("return did not set global enable");
   vector_load_a: assert property (
      vector_take |-> vector_addr == VECTOR_ADDR && !global_irq_enable)
      else $error("bad vector or enable on take");
   irq_latency_a: assert property (
      $rose(req) ##1 req |=> vector_take)
      else $error("vector latency wrong");
   flag_set_a: assert property (
      events != 4'h0 && !other_rst
      |=> (flags & $past(events)) == $past(events))
      else $error("event did not set flag");
   ext_edge_a: assert property (
      $rose(ext_irq_pin_i) && option[B_EDGE_SEL] && !por_start
      && !other_rst |=> flags[SRC_EXT])
      else $error("rising edge missed");
   ovf_flag_a: assert property (
      $past(timer_zero_count_i) == 8'hff && timer_zero_count_i == 8'h00
      && !por_start && !other_rst |=> flags[SRC_OVF])
      else $error("rollover missed");
   sleep_nop_a: assert property (
      sleep_op_i && running && !global_irq_enable && pending && ext_reset_n_i
      && !watchdog_timeout_i && !watchdog_clear_op_i
      |=> !asleep && $stable(cause) && !wdt_clear)
      else $error("sleep not a no-op");
   sleep_wake_a: assert property (
      asleep && pending && ext_reset_n_i && !core_hold
      && !watchdog_timeout_i |=> !asleep && cause == 2'h2)
      else $error("no wake on pending source");
   cause_wdt_a: assert property (
      wdt_rst && ext_reset_n_i |=> cause == 2'h1 && core_hold)
      else $error("watchdog reset cause wrong");

   fall_edge_a: assert property (
      $fell(ext_irq_pin_i) && !option[B_EDGE_SEL] && !por_start
      && !other_rst |=> flags[SRC_EXT])
      else $error("falling edge missed");
   pc_flag_a: assert property (
      upper_nibble_port_i != $past(upper_nibble_port_i) && !por_start
      |=> flags[SRC_PC])
      else $error("port change missed");
   ee_flag_a: assert property (
      ee_write_done_i |=> flags[SRC_EE])
      else $error("write done missed");
   no_wake_a: assert property (
      asleep && !pending && !watchdog_timeout_i && ext_reset_n_i
      && !core_hold |=> asleep)
      else $error("woke with no enabled source");
   hold_rst_a: assert property (
      !ext_reset_n_i |=> core_hold && cause.wdt_expiry)
      else $error("external reset not held");
   por_hold_a: assert property (
      por_phase && tmr_busy |=> core_hold)
      else $error("core released during start-up");

   // helper: cycles from a wake to the end of its delay
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wake_wait <= 11'h000;
      end else if (wake_now) begin
         wake_wait <= 11'h001;
      end else if (wake_wait != 11'h000 && tmr_busy) begin
         wake_wait <= wake_wait + 11'h001;
      end else begin
         wake_wait <= 11'h000;
      end
   end

   wake_delay_a: assert property (
      wake_wait != 11'h000 && !tmr_busy && !cfg_rc_mode_i
      |-> wake_wait == 11'(OST_CYCLES + 1))
      else $error("wake delay length wrong");

   take_c:  cover property (vector_take);
   sleep_c: cover property (sleep_do);
   wake_c:  cover property (wake_wait != 11'h000 && !tmr_busy);
   nop_c:   cover property (sleep_op_i && running && !sleep_do);
   rc_c:    cover property (por_start && cfg_rc_mode_i && !cfg_powerup_delay_timer_en_i);
endmodule

// ==== dv/source_core_model.sv ====
// far-side model: event sources and core operations
module source_core_model (
   // clock
   input  wire logic       core_clk_i,
   // sources
   output logic            ext_irq_pin_o,
   output logic      [3:0] upper_nibble_port_o,
   output logic      [7:0] timer_zero_count_o,
   output logic            ee_write_done_o,
   // core operations
   output logic            return_from_irq_op_o,
   output logic            sleep_op_o,
   output logic            watchdog_clear_op_o
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      ext_irq_pin_o = 1'b0;
      upper_nibble_port_o = 4'h0;
      timer_zero_count_o = 8'h00;
      ee_write_done_o = 1'b0;
      return_from_irq_op_o = 1'b0;
      sleep_op_o = 1'b0;
      watchdog_clear_op_o = 1'b0;
   end

   task automatic set_pin(input logic v);
      @(posedge core_clk_i);
      ext_irq_pin_o <= v;
   endtask

   task automatic change_port;
      @(posedge core_clk_i);
      upper_nibble_port_o <= upper_nibble_port_o ^ 4'h8;
      repeat (2) @(posedge core_clk_i);
   endtask

   task automatic roll_timer;
      @(posedge core_clk_i);
      timer_zero_count_o <= 8'hff;
      @(posedge core_clk_i);
      timer_zero_count_o <= 8'h00;
   endtask

   task automatic ee_done;
      @(posedge core_clk_i);
      ee_write_done_o <= 1'b1;
      @(posedge core_clk_i);
      ee_write_done_o <= 1'b0;
   endtask

   task automatic ret_irq;
      @(posedge core_clk_i);
      return_from_irq_op_o <= 1'b1;
      @(posedge core_clk_i);
      return_from_irq_op_o <= 1'b0;
   endtask

   task automatic enter_sleep;
      @(posedge core_clk_i);
      watchdog_clear_op_o <= 1'b1;
      @(posedge core_clk_i);
      watchdog_clear_op_o <= 1'b0;
      sleep_op_o <= 1'b1;
      @(posedge core_clk_i);
      sleep_op_o <= 1'b0;
   endtask
endmodule

// ==== dv/irq_wake_reset_status_tb.sv ====
// self-checking bench for the irq, wake and reset status block
module irq_wake_reset_status_tb
   import irq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int POWERUP_DELAY_TIMER_SIM = 20;
   localparam int OST_SIM  = 8;

   typedef struct packed {
      logic [7:0] opt;
      logic [1:0] src;
      logic [7:0] ctrl;
      logic [7:0] ee;
   } row_s;

   logic              core_clk_i;
   logic              resetn_i;
   logic        [2:0] addr_i;
   logic        [7:0] wr_data_i;
   logic              wr_i;
   logic              rd_i;
   logic        [7:0] rd_data_o;
   logic              ext_reset_n_i;
   logic              watchdog_timeout_i;
   logic              pin;
   logic        [3:0] port;
   logic        [7:0] tmr;
   logic              ee_done;
   logic              ret_op;
   logic              sleep_op;
   logic              clr_op;
   logic              powerup_delay_timer_en;
   logic              rc_mode;
   logic              core_hold_o;
   logic              core_run_o;
   logic              asleep_o;
   logic              vector_take_o;
   logic       [12:0] vector_addr_o;
   logic              watchdog_clear_o;
   reset_cause_s      cause_o;
   int                mismatches;
   int                comparisons;
   int                n;
   row_s              rows [5];

   irq_wake_reset_status #(
      .POWERUP_DELAY_TIMER_CYCLES (POWERUP_DELAY_TIMER_SIM),
      .OST_CYCLES  (OST_SIM)
   ) u_irq_wake_reset_status (
      .core_clk_i           (core_clk_i),
      .resetn_i             (resetn_i),
      .addr_i               (addr_i),
      .wr_data_i            (wr_data_i),
      .wr_i                 (wr_i),
      .rd_i                 (rd_i),
      .rd_data_o            (rd_data_o),
      .cfg_powerup_delay_timer_en_i        (powerup_delay_timer_en),
      .cfg_rc_mode_i        (rc_mode),
      .ext_reset_n_i        (ext_reset_n_i),
      .watchdog_timeout_i   (watchdog_timeout_i),
      .ext_irq_pin_i        (pin),
      .upper_nibble_port_i  (port),
      .timer_zero_count_i   (tmr),
      .ee_write_done_i      (ee_done),
      .return_from_irq_op_i (ret_op),
      .sleep_op_i           (sleep_op),
      .watchdog_clear_op_i  (clr_op),
      .core_hold_o          (core_hold_o),
      .core_run_o           (core_run_o),
      .asleep_o             (asleep_o),
      .vector_take_o        (vector_take_o),
      .vector_addr_o        (vector_addr_o),
      .watchdog_clear_o     (watchdog_clear_o),
      .cause_o              (cause_o)
   );

   source_core_model u_source_core_model (
      .core_clk_i           (core_clk_i),
      .ext_irq_pin_o        (pin),
      .upper_nibble_port_o  (port),
      .timer_zero_count_o   (tmr),
      .ee_write_done_o      (ee_done),
      .return_from_irq_op_o (ret_op),
      .sleep_op_o           (sleep_op),
      .watchdog_clear_op_o  (clr_op)
   );

   task automatic tally_and_finish;
      if (mismatches == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      @(negedge core_clk_i);
      check(rd_data_o, exp);
   endtask

   // sel 0 vector taken, 1 core running, 2 awake; n past lim on a miss
   task automatic wait_for(input int sel, input int lim, output int cnt);
      logic hit;
      cnt = 0;
      hit = 1'b0;
      while (!hit && cnt < lim) begin
         @(negedge core_clk_i);
         cnt++;
         hit = (sel == 0) ? (vector_take_o === 1'b1) :
               (sel == 1) ? (core_run_o === 1'b1) : (asleep_o === 1'b0);
      end
      if (!hit) cnt++;
   endtask

   task automatic no_take(input int cyc);
      logic seen;
      seen = 1'b0;
      repeat (cyc) begin
         @(negedge core_clk_i);
         seen |= (vector_take_o !== 1'b0);
      end
      check(seen, 1'b0);
   endtask

   task automatic fire_pin;
      u_source_core_model.set_pin(1'b1);
      u_source_core_model.set_pin(1'b0);
   endtask

   task automatic wdt_pulse;
      @(posedge core_clk_i);
      watchdog_timeout_i <= 1'b1;
      @(posedge core_clk_i);
      watchdog_timeout_i <= 1'b0;
   endtask

   initial begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end

   initial begin
      repeat (3000) @(posedge core_clk_i);
      mismatches++;
      tally_and_finish();
   end

   initial begin
      resetn_i = 1'b0;
      addr_i = 3'h0;
      wr_data_i = 8'h00;
      wr_i = 1'b0;
      rd_i = 1'b0;
      ext_reset_n_i = 1'b1;
      watchdog_timeout_i = 1'b0;
      powerup_delay_timer_en = 1'b1;
      rc_mode = 1'b0;
      mismatches = 0;
      comparisons = 0;
      rows[0] = '{8'hff, 2'd0, 8'h02, 8'h00};
      rows[1] = '{8'hbf, 2'd0, 8'h02, 8'h00};
      rows[2] = '{8'hff, 2'd1, 8'h04, 8'h00};
      rows[3] = '{8'hff, 2'd2, 8'h01, 8'h00};
      rows[4] = '{8'hff, 2'd3, 8'h00, 8'h10};
      repeat (10) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      wait_for(1, 40, n);
      check(n >= POWERUP_DELAY_TIMER_SIM + OST_SIM && n <= POWERUP_DELAY_TIMER_SIM + OST_SIM + 5, 1);
      rd_reg(ADDR_CTRL, 8'h00);
      rd_reg(ADDR_OPTION, 8'hff);
      rd_reg(ADDR_STATUS, 8'h03);
      wr_reg(ADDR_STATUS, 8'h00);
      rd_reg(ADDR_STATUS, 8'h03);
      wr_reg(3'h6, 8'hff);
      rd_reg(3'h6, 8'h00);
      foreach (rows[i]) begin
         wr_reg(ADDR_OPTION, rows[i].opt);
         wr_reg(ADDR_CTRL, 8'h00);
         wr_reg(ADDR_EECTRL, 8'h00);
         case (rows[i].src)
            2'd0: fire_pin();
            2'd1: u_source_core_model.roll_timer();
            2'd2: u_source_core_model.change_port();
            default: u_source_core_model.ee_done();
         endcase
         repeat (3) @(posedge core_clk_i);
         rd_reg(ADDR_CTRL, rows[i].ctrl);
         rd_reg(ADDR_EECTRL, rows[i].ee);
      end
      wr_reg(ADDR_CTRL, 8'h90);
      u_source_core_model.set_pin(1'b1);
      wait_for(0, 8, n);
      check(n >= 3 && n <= 5, 1);
      check(vector_addr_o, 13'h0004);
      rd_reg(ADDR_CTRL, 8'h12);
      u_source_core_model.set_pin(1'b0);
      wr_reg(ADDR_CTRL, 8'h10);
      u_source_core_model.ret_irq();
      rd_reg(ADDR_CTRL, 8'h90);
      no_take(6);
      wr_reg(ADDR_CTRL, 8'h10);
      fire_pin();
      no_take(8);
      rd_reg(ADDR_CTRL, 8'h12);
      u_source_core_model.enter_sleep();
      @(negedge core_clk_i);
      check(watchdog_clear_o, 1'b0);
      repeat (2) @(negedge core_clk_i);
      check(asleep_o, 1'b0);
      check(cause_o, 2'b11);
      wr_reg(ADDR_CTRL, 8'h10);
      u_source_core_model.enter_sleep();
      @(negedge core_clk_i);
      check({asleep_o, cause_o}, 3'b110);
      check(watchdog_clear_o, 1'b1);
      fire_pin();
      wait_for(2, 6, n);
      check(n <= 6, 1);
      check(cause_o, 2'b10);
      wait_for(1, 20, n);
      check(n >= OST_SIM && n <= OST_SIM + 5, 1);
      no_take(8);
      wr_reg(ADDR_CTRL, 8'h00);
      u_source_core_model.enter_sleep();
      fire_pin();
      @(negedge core_clk_i);
      check(asleep_o, 1'b1);
      wdt_pulse();
      wait_for(2, 6, n);
      check(cause_o, 2'b00);
      wait_for(1, 20, n);
      check(n >= OST_SIM && n <= OST_SIM + 5, 1);
      wr_reg(ADDR_CTRL, 8'h80);
      wdt_pulse();
      @(negedge core_clk_i);
      check(cause_o, 2'b01);
      check(core_hold_o, 1'b1);
      wait_for(1, 40, n);
      rd_reg(ADDR_CTRL, 8'h00);
      @(posedge core_clk_i);
      resetn_i <= 1'b0;
      ext_reset_n_i <= 1'b0;
      repeat (10) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      repeat (40) @(posedge core_clk_i);
      ext_reset_n_i <= 1'b1;
      wait_for(1, 4, n);
      check(n <= 3, 1);
      check(cause_o, 2'b11);
      // rc mode, no power-up delay: no start-up or wake delay
      @(posedge core_clk_i);
      resetn_i <= 1'b0;
      powerup_delay_timer_en <= 1'b0;
      rc_mode <= 1'b1;
      repeat (10) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      wait_for(1, 6, n);
      check(n, 4);
      wr_reg(ADDR_CTRL, 8'h10);
      u_source_core_model.enter_sleep();
      fire_pin();
      wait_for(2, 6, n);
      wait_for(1, 4, n);
      check(n, 1);
      tally_and_finish();
   end
endmodule
